// file: src/cio_line_ctrl.sv
// camera io line conditioning, output source selection and register slave
//
// The placing of the registers and the AXI4-Lite interface to the registers were chosen for this implementation.
module cio_line_ctrl #(
	parameter int NUM_LINES = cio_pkg::CIO_NUM_LINES,
	parameter logic [7:0] OUT_MASK = cio_pkg::CIO_OUT_MASK
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// axi4-lite write address and data
	input wire logic [cio_pkg::CIO_ADDR_W-1:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	// axi4-lite read
	input wire logic [cio_pkg::CIO_ADDR_W-1:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	// camera events
	input wire cio_pkg::cio_evt_t evt_i,
	// physical lines
	input wire logic [NUM_LINES-1:0] line_in_i,
	output logic [NUM_LINES-1:0] line_out_o,
	output logic [NUM_LINES-1:0] line_oe_o
);
	import cio_pkg::*;

	//------------------------------------------------------------------
	// parameter check
	//------------------------------------------------------------------
	if (NUM_LINES < CIO_MIN_LINES || NUM_LINES > CIO_MAX_LINES ||
		OUT_MASK[CIO_ECHO_N-1:0] != '0) begin : g_bad_cfg
		$error("cio_line_ctrl: unsupported line count or direction mask");
	end

	// the microsecond prescaler must hold one microsecond of clocks
	if (CIO_CYC_PER_US < 1 ||
		CIO_CYC_PER_US > 2 ** CIO_SUB_W) begin : g_bad_clk
		$error("cio_line_ctrl: clock period does not suit the prescaler");
	end

	//------------------------------------------------------------------
	// configuration state
	//------------------------------------------------------------------
	logic [CIO_SEL_W-1:0] sel_q;
	logic [NUM_LINES-1:0] inv_q;
	logic [NUM_LINES-1:0] swval_q;
	logic [CIO_DEB_W-1:0] deb_q [NUM_LINES];
	cio_src_t src_q [NUM_LINES];
	logic [CIO_PW_W-1:0] pw_q;

	logic [NUM_LINES-1:0] sync1_q;
	logic [NUM_LINES-1:0] sync2_q;
	logic [NUM_LINES-1:0] level_w;
	logic [NUM_LINES-1:0] echo_w;

	//------------------------------------------------------------------
	// axi4-lite write channel
	//------------------------------------------------------------------
	logic aw_have_q;
	logic w_have_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic [CIO_ADDR_W-1:0] waddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;

	wire logic aw_take = s_axi_awvalid_i && s_axi_awready_o;
	wire logic w_take = s_axi_wvalid_i && s_axi_wready_o;
	wire logic do_write = aw_have_q && w_have_q && !bvalid_q;
	wire cio_reg_t wr_id = cio_reg_decode(waddr_q);
	// status is read only, so a write to it is refused and changes nothing
	wire logic wr_bad = (wr_id == CIO_REG_NONE) || (wr_id == CIO_REG_STAT);
	wire logic [1:0] wr_resp = wr_bad ? CIO_RESP_SLVERR : CIO_RESP_OKAY;

	assign s_axi_awready_o = !aw_have_q && !bvalid_q;
	assign s_axi_wready_o = !w_have_q && !bvalid_q;
	assign s_axi_bvalid_o = bvalid_q;
	assign s_axi_bresp_o = bresp_q;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			waddr_q <= '0;
			wdata_q <= 32'h0;
			wstrb_q <= 4'h0;
		end else begin
			if (aw_take) begin
				aw_have_q <= 1'b1;
				waddr_q <= s_axi_awaddr_i;
			end else if (do_write) begin
				aw_have_q <= 1'b0;
			end
			if (w_take) begin
				w_have_q <= 1'b1;
				wdata_q <= s_axi_wdata_i;
				wstrb_q <= s_axi_wstrb_i;
			end else if (do_write) begin
				w_have_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			bvalid_q <= 1'b0;
			bresp_q <= CIO_RESP_OKAY;
		end else if (do_write) begin
			bvalid_q <= 1'b1;
			bresp_q <= wr_resp;
		end else if (s_axi_bready_i) begin
			bvalid_q <= 1'b0;
		end
	end

	//------------------------------------------------------------------
	// selected line view
	//------------------------------------------------------------------
	// a selector past the last line reads as zero and ignores writes
	wire logic sel_ok = 32'(sel_q) < NUM_LINES;
	wire logic sel_inv = sel_ok && inv_q[sel_q];
	wire logic sel_swv = sel_ok && swval_q[sel_q];
	wire logic [CIO_DEB_W-1:0] sel_deb = sel_ok ? deb_q[sel_q] : '0;
	wire logic [3:0] sel_src = sel_ok ? src_q[sel_q] : 4'h0;
	wire logic sel_dir = sel_ok && OUT_MASK[sel_q];
	wire logic sel_level = sel_ok && level_w[sel_q];

	//------------------------------------------------------------------
	// register words; the per line ones are indexed through the line selector
	//------------------------------------------------------------------
	logic [CIO_NREG-1:0][31:0] words;

	assign words[CIO_REG_SEL] = 32'(sel_q);
	assign words[CIO_REG_INV] = 32'(sel_inv);
	assign words[CIO_REG_DEB] = 32'(sel_deb);
	assign words[CIO_REG_SRC] = 32'(sel_src);
	assign words[CIO_REG_SWV] = 32'(sel_swv);
	assign words[CIO_REG_STAT] =
		(32'(sel_dir) << CIO_ST_DIR_BIT) |
		(32'(sel_level) << CIO_ST_LEVEL_BIT);
	assign words[CIO_REG_PW] = 32'(pw_q);

	wire logic [31:0] wr_merged =
		cio_merge(cio_pick(wr_id, words), wdata_q, wstrb_q);

	// per line fields only land on a selected line that exists
	wire logic wr_line = do_write && sel_ok;
	wire logic wr_sel = do_write && (wr_id == CIO_REG_SEL);
	wire logic wr_pw = do_write && (wr_id == CIO_REG_PW);
	wire logic wr_inv = wr_line && (wr_id == CIO_REG_INV);
	wire logic wr_swv = wr_line && (wr_id == CIO_REG_SWV);
	wire logic wr_deb = wr_line && (wr_id == CIO_REG_DEB);
	wire logic wr_src = wr_line && (wr_id == CIO_REG_SRC);

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sel_q <= '0;
			pw_q <= CIO_PW_RST;
			inv_q <= '0;
			swval_q <= '0;
			for (int k = 0; k < NUM_LINES; k++) begin
				deb_q[k] <= CIO_DEB_RST;
				src_q[k] <= CIO_SRC_OFF;
			end
		end else begin
			if (wr_sel) sel_q <= wr_merged[CIO_SEL_W-1:0];
			if (wr_pw) pw_q <= wr_merged[CIO_PW_W-1:0];
			if (wr_inv) inv_q[sel_q] <= wr_merged[0];
			if (wr_swv) swval_q[sel_q] <= wr_merged[0];
			if (wr_deb) deb_q[sel_q] <= wr_merged[CIO_DEB_W-1:0];
			if (wr_src) src_q[sel_q] <= cio_src_t'(wr_merged[3:0]);
		end
	end

	//------------------------------------------------------------------
	// axi4-lite read channel
	//------------------------------------------------------------------
	logic rvalid_q;
	logic [1:0] rresp_q;
	logic [31:0] rdata_q;

	wire cio_reg_t rd_id = cio_reg_decode(s_axi_araddr_i);
	wire logic ar_take = s_axi_arvalid_i && s_axi_arready_o;

	assign s_axi_arready_o = !rvalid_q;
	assign s_axi_rvalid_o = rvalid_q;
	assign s_axi_rresp_o = rresp_q;
	assign s_axi_rdata_o = rdata_q;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rvalid_q <= 1'b0;
			rresp_q <= CIO_RESP_OKAY;
			rdata_q <= 32'h0;
		end else if (ar_take) begin
			rvalid_q <= 1'b1;
			rdata_q <= cio_pick(rd_id, words);
			rresp_q <= (rd_id == CIO_REG_NONE) ? CIO_RESP_SLVERR :
				CIO_RESP_OKAY;
		end else if (s_axi_rready_i) begin
			rvalid_q <= 1'b0;
		end
	end

	//------------------------------------------------------------------
	// pin synchroniser and event edges
	//------------------------------------------------------------------
	logic line_act_q;
	logic frame_act_q;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sync1_q <= '0;
			sync2_q <= '0;
			line_act_q <= 1'b0;
			frame_act_q <= 1'b0;
		end else begin
			sync1_q <= line_in_i;
			sync2_q <= sync1_q;
			line_act_q <= evt_i.line_active;
			frame_act_q <= evt_i.frame_active;
		end
	end

	//------------------------------------------------------------------
	// output triggers
	//------------------------------------------------------------------
	// active levels fire once on their rising edge, not while they stay up
	wire logic line_begin = evt_i.line_active && !line_act_q;
	wire logic frame_begin = evt_i.frame_active && !frame_act_q;

	// trigger per source code; off and software level never fire
	wire logic [CIO_NSRC-1:0] src_trig = {
		evt_i.exposure_begin,
		evt_i.net_cmd_b,
		evt_i.net_cmd_a,
		echo_w[2],
		echo_w[1],
		echo_w[0],
		frame_begin,
		evt_i.acq_finish,
		evt_i.acq_begin,
		evt_i.rejected_trig,
		line_begin,
		2'b00
	};

	//------------------------------------------------------------------
	// per line logic
	//------------------------------------------------------------------
	// inputs: pin, two flops, invert, debounce, rising edge for echo
	// outputs: source mux, invert, one flop; direction is fixed per line
	for (genvar i = 0; i < NUM_LINES; i++) begin : g_line
		if (!OUT_MASK[i]) begin : g_in
			// counts whole microseconds, so a mid-period glitch restarts
			wire logic raw = sync2_q[i] ^ inv_q[i];
			logic [CIO_SUB_W-1:0] sub_q;
			logic [CIO_DEB_W-1:0] us_q;
			logic filt_q;
			logic prev_q;
			wire logic settled = raw == filt_q;
			wire logic held_long = us_q >= deb_q[i];
			wire logic us_tick = sub_q == CIO_SUB_LAST;

			always_ff @(posedge clk_i or posedge rst_i) begin
				if (rst_i) begin
					sub_q <= '0;
					us_q <= '0;
					filt_q <= 1'b0;
				end else if (settled) begin
					sub_q <= '0;
					us_q <= '0;
				end else if (held_long) begin
					filt_q <= raw;
				end else if (us_tick) begin
					sub_q <= '0;
					us_q <= us_q + 1'b1;
				end else begin
					sub_q <= sub_q + 1'b1;
				end
			end

			always_ff @(posedge clk_i or posedge rst_i) begin
				if (rst_i) prev_q <= 1'b0;
				else prev_q <= filt_q;
			end

			assign level_w[i] = filt_q;
			assign echo_w[i] = filt_q && !prev_q;
			// inputs are never driven by the source mux
			assign line_out_o[i] = 1'b0;
			assign line_oe_o[i] = 1'b0;
		end else begin : g_out
			wire cio_src_t src = src_q[i];
			wire logic known = 32'(src) < CIO_NSRC;
			wire logic pulsed = known && (src > CIO_SRC_SW_LEVEL);
			wire logic fire = pulsed && src_trig[src];
			logic [CIO_PW_W-1:0] pcnt_q;
			logic out_q;
			logic oe_q;

			// a new trigger restarts the pulse rather than stretching it
			// a width of zero gives no pulse at all
			always_ff @(posedge clk_i or posedge rst_i) begin
				if (rst_i) pcnt_q <= '0;
				else if (fire) pcnt_q <= pw_q;
				else if (pcnt_q != '0) pcnt_q <= pcnt_q - 1'b1;
			end

			wire logic pulse_on = pulsed && (pcnt_q != '0);
			wire logic mux = (src == CIO_SRC_SW_LEVEL) ? swval_q[i] :
				pulse_on;
			wire logic drive = known && (src != CIO_SRC_OFF);

			always_ff @(posedge clk_i or posedge rst_i) begin
				if (rst_i) begin
					out_q <= 1'b0;
					oe_q <= 1'b0;
				end else begin
					out_q <= mux ^ inv_q[i];
					oe_q <= drive;
				end
			end

			assign level_w[i] = out_q;
			assign echo_w[i] = 1'b0;
			assign line_out_o[i] = out_q;
			assign line_oe_o[i] = oe_q;
		end
	end

endmodule

// file: include/cio_pkg.sv
// constants, types and register map of the camera io line control block
//----------------------------------------------------------------------
// What this block does
// - invert the selected line's signal when its invert setting is set
// - accept an input level only after it holds for the debounce time
// - output source selector picks what drives a line; off leaves open
// - source selection acts only on lines whose direction is output
// - software source drives the line to the software level setting
// - line begin source pulses when line active rises
// - rejected trigger source pulses on each rejected line trigger
// - acquisition begin source pulses on the acquisition start event
// - acquisition finish source pulses on the acquisition stop event
// - frame begin source pulses when frame active rises
// - echo sources pulse when input line a, b or c pulses
// - network command sources pulse on action command a or b
// - exposure begin source pulses when exposure starts
// - report read only whether the selected line is input or output
// - report read only the present level of the selected line
//----------------------------------------------------------------------
package cio_pkg;

	//------------------------------------------------------------------
	// geometry and timing
	//------------------------------------------------------------------
	localparam int CIO_NUM_LINES = 5;
	localparam int CIO_MIN_LINES = 3;
	localparam int CIO_MAX_LINES = 8;
	localparam int CIO_ECHO_N = 3;
	localparam logic [7:0] CIO_OUT_MASK = 8'h18;
	localparam int CIO_CLK_PERIOD_NS = 20;
	localparam int CIO_US_NS = 1000;
	localparam int CIO_CYC_PER_US =
		(CIO_US_NS + CIO_CLK_PERIOD_NS - 1) / CIO_CLK_PERIOD_NS;
	localparam int CIO_SUB_W = 6;
	localparam logic [CIO_SUB_W-1:0] CIO_SUB_LAST =
		CIO_SUB_W'(CIO_CYC_PER_US - 1);
	localparam int CIO_SEL_W = 3;
	localparam int CIO_DEB_W = 16;
	localparam int CIO_PW_W = 16;
	localparam logic [CIO_DEB_W-1:0] CIO_DEB_RST = 16'h000a;
	localparam logic [CIO_PW_W-1:0] CIO_PW_RST = 16'h0032;

	//------------------------------------------------------------------
	// register map (byte addresses)
	//------------------------------------------------------------------
	localparam int CIO_ADDR_W = 8;
	localparam logic [7:0] CIO_OFF_SEL = 8'h00;
	localparam logic [7:0] CIO_OFF_INV = 8'h04;
	localparam logic [7:0] CIO_OFF_DEB = 8'h08;
	localparam logic [7:0] CIO_OFF_SRC = 8'h0c;
	localparam logic [7:0] CIO_OFF_SWV = 8'h10;
	localparam logic [7:0] CIO_OFF_STAT = 8'h14;
	localparam logic [7:0] CIO_OFF_PW = 8'h18;
	localparam int CIO_ST_LEVEL_BIT = 0;
	localparam int CIO_ST_DIR_BIT = 1;
	localparam logic [1:0] CIO_RESP_OKAY = 2'h0;
	localparam logic [1:0] CIO_RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		CIO_REG_SEL = 3'h0,
		CIO_REG_INV = 3'h1,
		CIO_REG_DEB = 3'h2,
		CIO_REG_SRC = 3'h3,
		CIO_REG_SWV = 3'h4,
		CIO_REG_STAT = 3'h5,
		CIO_REG_PW = 3'h6,
		CIO_REG_NONE = 3'h7
	} cio_reg_t;
	localparam int CIO_NREG = 7;

	//------------------------------------------------------------------
	// output sources
	//------------------------------------------------------------------
	typedef enum logic [3:0] {
		CIO_SRC_OFF = 4'h0,
		CIO_SRC_SW_LEVEL = 4'h1,
		CIO_SRC_LINE_BEGIN = 4'h2,
		CIO_SRC_REJECTED_TRIG = 4'h3,
		CIO_SRC_ACQ_BEGIN = 4'h4,
		CIO_SRC_ACQ_FINISH = 4'h5,
		CIO_SRC_FRAME_BEGIN = 4'h6,
		CIO_SRC_ECHO_IN_A = 4'h7,
		CIO_SRC_ECHO_IN_B = 4'h8,
		CIO_SRC_ECHO_IN_C = 4'h9,
		CIO_SRC_NET_CMD_A = 4'ha,
		CIO_SRC_NET_CMD_B = 4'hb,
		CIO_SRC_EXPOSURE_BEGIN = 4'hc
	} cio_src_t;
	localparam int CIO_NSRC = 13;

	// internal camera events, all on clk_i
	typedef struct packed {
		logic line_active;
		logic rejected_trig;
		logic acq_begin;
		logic acq_finish;
		logic frame_active;
		logic net_cmd_a;
		logic net_cmd_b;
		logic exposure_begin;
	} cio_evt_t;

	function automatic cio_reg_t cio_reg_decode(
		input logic [CIO_ADDR_W-1:0] a
	);
		cio_reg_t r;
		r = CIO_REG_NONE;
		if (a[7:2] == CIO_OFF_SEL[7:2]) r = CIO_REG_SEL;
		if (a[7:2] == CIO_OFF_INV[7:2]) r = CIO_REG_INV;
		if (a[7:2] == CIO_OFF_DEB[7:2]) r = CIO_REG_DEB;
		if (a[7:2] == CIO_OFF_SRC[7:2]) r = CIO_REG_SRC;
		if (a[7:2] == CIO_OFF_SWV[7:2]) r = CIO_REG_SWV;
		if (a[7:2] == CIO_OFF_STAT[7:2]) r = CIO_REG_STAT;
		if (a[7:2] == CIO_OFF_PW[7:2]) r = CIO_REG_PW;
		return r;
	endfunction

	function automatic logic [31:0] cio_pick(
		input cio_reg_t id,
		input logic [CIO_NREG-1:0][31:0] words
	);
		logic [31:0] r;
		r = 32'h0;
		if (id != CIO_REG_NONE) r = words[id];
		return r;
	endfunction

	function automatic logic [31:0] cio_merge(
		input logic [31:0] old,
		input logic [31:0] nw,
		input logic [3:0] strb
	);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) r[8*b +: 8] = nw[8*b +: 8];
		end
		return r;
	endfunction

endpackage

// file: tb/cio_ext_equip.sv
// external trigger and strobe equipment seen at the camera io lines
module cio_ext_equip (
	// camera side
	input wire logic [4:0] line_out_i,
	input wire logic [4:0] line_oe_i,
	// pins seen by the camera
	output logic [4:0] line_in_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [4:0] pins_q = 5'h00;
	// a driven pin follows the camera, a free one follows the equipment
	assign line_in_o = (line_oe_i & line_out_i) | (~line_oe_i & pins_q);
	task automatic drive(input int idx, input logic v);
		pins_q[idx] <= v;
	endtask
endmodule

// file: tb/cio_line_ctrl_assertions.sv
// concurrent checks on the camera io line control ports
module cio_line_ctrl_assertions #(
	parameter int NUM_LINES = cio_pkg::CIO_NUM_LINES,
	parameter logic [7:0] OUT_MASK = cio_pkg::CIO_OUT_MASK
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// register bus
	input wire logic s_axi_awvalid_i,
	input wire logic s_axi_awready_o,
	input wire logic s_axi_wvalid_i,
	input wire logic s_axi_wready_o,
	input wire logic [1:0] s_axi_bresp_o,
	input wire logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [cio_pkg::CIO_ADDR_W-1:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	input wire logic s_axi_arready_o,
	input wire logic [31:0] s_axi_rdata_o,
	input wire logic [1:0] s_axi_rresp_o,
	input wire logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	// lines
	input wire logic [NUM_LINES-1:0] line_out_o,
	input wire logic [NUM_LINES-1:0] line_oe_o
);
	import cio_pkg::*;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire logic [NUM_LINES-1:0] in_lines = ~OUT_MASK[NUM_LINES-1:0];
	wire logic aw_go = s_axi_awvalid_i && s_axi_awready_o;
	wire logic w_go = s_axi_wvalid_i && s_axi_wready_o;
	wire logic ar_go = s_axi_arvalid_i && s_axi_arready_o;

	a_input_oe_low: assert property (!(|(line_oe_o & in_lines)))
		else $error("input line enable high");
	a_input_out_low: assert property (!(|(line_out_o & in_lines)))
		else $error("input line level driven");
	a_write_answer: assert property (aw_go && w_go |-> ##2 s_axi_bvalid_o)
		else $error("write answer late");
	a_bresp_stand: assert property (s_axi_bvalid_o && !s_axi_bready_i
		|=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
		else $error("write response dropped");
	a_read_answer: assert property (ar_go |=> s_axi_rvalid_o)
		else $error("read answer late");
	a_rdata_stand: assert property (s_axi_rvalid_o && !s_axi_rready_i
		|=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
		else $error("read data dropped");
	a_unmapped_slverr: assert property (ar_go && s_axi_araddr_i[7:2] > 6'h06
		|=> s_axi_rresp_o == CIO_RESP_SLVERR && s_axi_rdata_o == 32'h0)
		else $error("unmapped read not refused");
	a_busy_refuse: assert property (s_axi_bvalid_o |-> !s_axi_awready_o
		&& !s_axi_wready_o && !(s_axi_rvalid_o && s_axi_arready_o))
		else $error("ready while busy");
	c_write: cover property (aw_go && w_go);
	c_bad_read: cover property (ar_go && s_axi_araddr_i[7:2] > 6'h06);
	c_pulse: cover property ($rose(line_out_o[NUM_LINES-1]));
endmodule

bind cio_line_ctrl cio_line_ctrl_assertions #(.NUM_LINES(NUM_LINES),
	.OUT_MASK(OUT_MASK)) i_chk (.clk_i(clk_i), .rst_i(rst_i),
	.s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
	.s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
	.s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
	.s_axi_bready_i(s_axi_bready_i), .s_axi_araddr_i(s_axi_araddr_i),
	.s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
	.s_axi_rdata_o(s_axi_rdata_o), .s_axi_rresp_o(s_axi_rresp_o),
	.s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i),
	.line_out_o(line_out_o), .line_oe_o(line_oe_o));

// file: tb/tb.sv
// self-checking bench for the camera io line control block
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import cio_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, rd;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic [3:0] wstrb = 4'hf;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [4:0] line_in, line_out, line_oe;
	cio_evt_t evt = cio_evt_t'(8'h00);
	int errors = 0, comparisons = 0, hi_cnt = 0, b;
	logic [3:0] srcs [8] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'ha, 4'hb, 4'hc};

	always #10 clk_i = ~clk_i;
	// counted on the falling edge, where outputs are settled
	always @(negedge clk_i) if (line_out[4] === 1'b1) hi_cnt++;

	cio_line_ctrl i_dut (.clk_i(clk_i), .rst_i(rst_i),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
		.s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
		.s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
		.s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
		.s_axi_rready_i(rready), .evt_i(evt), .line_in_i(line_in),
		.line_out_o(line_out), .line_oe_o(line_oe));
	cio_ext_equip i_ext (.line_out_i(line_out), .line_oe_i(line_oe),
		.line_in_o(line_in));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: %s got %h", $time, what, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		@(posedge clk_i);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge clk_i);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		bready <= 1'b0;
		chk({30'h0, bresp}, {30'h0, er}, "bresp");
	endtask
	task automatic rdr(input logic [7:0] a, input logic [1:0] er);
		@(posedge clk_i);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge clk_i);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		rd = rdata;
		rready <= 1'b0;
		chk({30'h0, rresp}, {30'h0, er}, "rresp");
	endtask
	task automatic pulse(input int bit_n, input int exp);
		hi_cnt = 0;
		@(posedge clk_i);
		evt <= cio_evt_t'(8'h01 << bit_n);
		@(posedge clk_i);
		evt <= cio_evt_t'(8'h00);
		repeat (12) @(posedge clk_i);
		chk(hi_cnt, exp, "pulse cycles");
	endtask
	task automatic end_sim();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk_i);
		errors++;
		$display("mismatch at %0t: watchdog expired", $time);
		end_sim();
	end

	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		rdr(CIO_OFF_PW, CIO_RESP_OKAY);
		chk(rd, 32'h32, "pw reset");
		rdr(CIO_OFF_DEB, CIO_RESP_OKAY);
		chk(rd, 32'ha, "debounce reset");
		rdr(CIO_OFF_STAT, CIO_RESP_OKAY);
		chk(rd & 32'h2, 32'h0, "line 0 direction");
		rdr(8'h40, CIO_RESP_SLVERR);
		chk(rd, 32'h0, "unmapped read");
		wr(CIO_OFF_STAT, 32'h3, CIO_RESP_SLVERR);
		// only byte 1 strobed: the low byte keeps its reset value
		wstrb <= 4'h2;
		wr(CIO_OFF_PW, 32'h0000ab99, CIO_RESP_OKAY);
		wstrb <= 4'hf;
		rdr(CIO_OFF_PW, CIO_RESP_OKAY);
		chk(rd, 32'hab32, "strobed write");
		$display("test reset and map done");
		// software level on line 3
		wr(CIO_OFF_SEL, 32'h3, CIO_RESP_OKAY);
		rdr(CIO_OFF_STAT, CIO_RESP_OKAY);
		chk(rd & 32'h2, 32'h2, "line 3 direction");
		wr(CIO_OFF_SRC, 32'h1, CIO_RESP_OKAY);
		wr(CIO_OFF_SWV, 32'h1, CIO_RESP_OKAY);
		repeat (2) @(posedge clk_i);
		chk({line_oe[3], line_out[3]}, 32'h3, "sw level");
		rdr(CIO_OFF_STAT, CIO_RESP_OKAY);
		chk(rd, 32'h3, "output readback");
		wr(CIO_OFF_INV, 32'h1, CIO_RESP_OKAY);
		repeat (2) @(posedge clk_i);
		chk(line_out[3], 32'h0, "inverted level");
		wr(CIO_OFF_SRC, 32'h0, CIO_RESP_OKAY);
		repeat (2) @(posedge clk_i);
		chk(line_oe[3], 32'h0, "off is open");
		$display("test software level done");
		// event pulses on line 4, three cycles wide
		wr(CIO_OFF_SEL, 32'h4, CIO_RESP_OKAY);
		wr(CIO_OFF_PW, 32'h3, CIO_RESP_OKAY);
		foreach (srcs[i]) begin
			b = (srcs[i] < 4'h7) ? 9 - srcs[i] : 12 - srcs[i];
			wr(CIO_OFF_SRC, {28'h0, srcs[i]}, CIO_RESP_OKAY);
			pulse(b, 3);
			pulse((b + 1) % 8, 0);
		end
		chk(line_oe[4], 32'h1, "pulse source drives");
		wr(CIO_OFF_SRC, 32'hd, CIO_RESP_OKAY);
		repeat (2) @(posedge clk_i);
		chk(line_oe[4], 32'h0, "unused code is open");
		$display("test event pulses done");
		// echo of debounced inputs a, b and c, 50 cycles debounce
		for (int i = 0; i < 3; i++) begin
			wr(CIO_OFF_SEL, 32'h4, CIO_RESP_OKAY);
			wr(CIO_OFF_SRC, 32'h7 + i, CIO_RESP_OKAY);
			wr(CIO_OFF_SEL, i, CIO_RESP_OKAY);
			wr(CIO_OFF_DEB, 32'h1, CIO_RESP_OKAY);
			hi_cnt = 0;
			i_ext.drive(i, 1'b1);
			repeat (30) @(posedge clk_i);
			i_ext.drive(i, 1'b0);
			repeat (60) @(posedge clk_i);
			chk(hi_cnt, 32'h0, "glitch ignored");
			i_ext.drive(i, 1'b1);
			repeat (80) @(posedge clk_i);
			chk(hi_cnt, 32'h3, "echo pulse");
			rdr(CIO_OFF_STAT, CIO_RESP_OKAY);
			chk(rd, 32'h1, "input readback");
		end
		wr(CIO_OFF_SEL, 32'h0, CIO_RESP_OKAY);
		wr(CIO_OFF_INV, 32'h1, CIO_RESP_OKAY);
		repeat (60) @(posedge clk_i);
		rdr(CIO_OFF_STAT, CIO_RESP_OKAY);
		chk(rd, 32'h0, "inverted input");
		$display("test input path done");
		end_sim();
	end
endmodule
